// File: hdl/css_pkg.sv
/*
 * Constants for the capacitive sensor status and readout block: register
 * byte offsets, field positions, reset values and tuning figures.
 * Assumes a host that reads and writes single register bytes by address.
 */
// Functional notes
// (RULE1) calibrated output flags at 37H bits 2:0
// (RULE2) output follows proximity, or touch when configured
// (RULE3) average freeze flags at 39H bits 2:0
// (RULE4) outside touch mode, proximity sets freeze flag
// (RULE5) touch enters touch mode, clears freeze flag
// (RULE6) self sensing: refreeze when count exceeds average+16
// (RULE7) projected sensing: refreeze when count below average-16
// (RULE8) active channel index 0..2 at 3DH
// (RULE9) active count high 42H, low 43H
// (RULE10) active average high 83H, low 84H
// (RULE11) tuning target is eight times byte C4H
// (RULE12) target byte resets to 128, target 1024
// (RULE13) host writes target/8 then requests retune
// (RULE14) all channels at target when busy clears; code also marks done a channel whose settings can step no further
// (RULE15) multiplier sensitivity four bits, 1111 highest count
// (RULE16) multiplier compensation two bits, coarsest effect
// (RULE17) tuning busy flag in system flags bit 2
// (RULE18) touch threshold exceeded enters touch mode
// (RULE19) sensing technology in system flags bit 4
// (RULE20) index, count and average update together
`default_nettype none
package css_pkg;
    localparam int         NUM_CH            = 3;
    localparam logic [7:0] ADDR_SYS_FLAGS    = 8'h10;
    localparam logic [7:0] ADDR_CAL_OUT      = 8'h37;
    localparam logic [7:0] ADDR_FREEZE       = 8'h39;
    localparam logic [7:0] ADDR_CH_INDEX     = 8'h3d;
    localparam logic [7:0] ADDR_COUNT_HI     = 8'h42;
    localparam logic [7:0] ADDR_COUNT_LO     = 8'h43;
    localparam logic [7:0] ADDR_AVG_HI       = 8'h83;
    localparam logic [7:0] ADDR_AVG_LO       = 8'h84;
    localparam logic [7:0] ADDR_TARGET       = 8'hc4;
    localparam int         SYS_BUSY_BIT      = 2;
    localparam int         SYS_TECH_BIT      = 4;
    localparam logic [7:0] TARGET_RESET      = 8'h80;
    localparam int         TARGET_SHIFT      = 3;
    localparam logic [15:0] FREEZE_MARGIN    = 16'h0010;
    localparam int         MSENS_W           = 4;
    localparam int         MCOMP_W           = 2;
    localparam int         COMP_W            = 8;
    localparam logic [MSENS_W-1:0] MSENS_RESET = 4'h0;
    localparam logic [MCOMP_W-1:0] MCOMP_RESET = 2'h0;
    localparam logic [COMP_W-1:0]  COMP_RESET  = 8'h00;
    localparam logic [15:0] TARGET_TOL       = 16'h0004;
endpackage : css_pkg
`default_nettype wire

// File: hdl/css_readout.sv
/*
 * Status, readout and automatic tuning logic of a three channel
 * capacitive sensor. The measurement front end supplies per-channel
 * detections and a count stream; the host reaches register bytes through
 * a simple address/strobe port. Inputs are from logic on i_core_clk.
 */
`default_nettype none
module css_readout (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst,
    // host byte port
    input  wire logic                    i_wr_en,
    input  wire logic                    i_rd_en,
    input  wire logic [7:0]              i_addr,
    input  wire logic [7:0]              i_wdata,
    output logic      [7:0]              o_rdata,
    output logic                         o_rvalid,
    // configuration and events
    input  wire logic [2:0]              i_calibrated_output_operation,
    input  wire logic                    i_output_on_touch,
    input  wire logic                    i_sensing_technology_flag,
    input  wire logic                    i_retune_req,
    input  wire logic [2:0]              i_prox_det,
    input  wire logic [2:0]              i_touch_det,
    // measurement front end
    input  wire logic                    i_sample_valid,
    input  wire logic [1:0]              i_sample_ch,
    input  wire logic [15:0]             i_sample_count,
    input  wire logic [15:0]             i_sample_average,
    // tuning settings applied to the front end
    output logic [3*css_pkg::MSENS_W-1:0] o_mult_sense,
    output logic [3*css_pkg::MCOMP_W-1:0] o_mult_comp,
    output logic [3*css_pkg::COMP_W-1:0]  o_comp,
    output logic                         o_tuning_busy_flag,
    output logic [15:0]                  o_tuning_target
);
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CSS_TUNE_IDLE = 2'b00,
        CSS_TUNE_WAIT = 2'b01,
        CSS_TUNE_STEP = 2'b11
    } css_tune_t;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0]  cal_out_q,  cal_out_d;
    logic [2:0]  freeze_q,   freeze_d;
    logic [2:0]  touch_mode_q, touch_mode_d;
    logic [1:0]  ch_index_q, ch_index_d;
    logic [15:0] count_q,    count_d;
    logic [15:0] average_q,  average_d;
    logic [7:0]  target_q,   target_d;
    logic [7:0]  rdata_q,    rdata_d;
    logic        rvalid_q,   rvalid_d;
    css_tune_t   tune_q,     tune_d;
    logic [2:0]  tuned_q,    tuned_d;
    logic [3*css_pkg::MSENS_W-1:0] msens_q, msens_d;
    logic [3*css_pkg::MCOMP_W-1:0] mcomp_q, mcomp_d;
    logic [3*css_pkg::COMP_W-1:0]  comp_q,  comp_d;

    logic [15:0] target_count;
    logic [15:0] diff_up;
    logic [15:0] diff_dn;
    logic [16:0] avg_plus;
    logic [16:0] cnt_plus;

    assign target_count = {5'h00, target_q, 3'h0}; // RULE11
    assign avg_plus     = {1'b0, i_sample_average} + {1'b0, css_pkg::FREEZE_MARGIN};
    assign cnt_plus     = {1'b0, i_sample_count} + {1'b0, css_pkg::FREEZE_MARGIN};
    // tuning step works on the stored snapshot; the live count is gone by then
    assign diff_up      = (target_count > count_q) ?
                          (target_count - count_q) : 16'h0000;
    assign diff_dn      = (count_q > target_count) ?
                          (count_q - target_count) : 16'h0000;

    // ------------------------------------------------------------------
    // channel status: output, touch mode, average freeze
    // ------------------------------------------------------------------
    always_comb
    begin
        cal_out_d    = cal_out_q;
        freeze_d     = freeze_q;
        touch_mode_d = touch_mode_q;
        for (int c = 0; c < css_pkg::NUM_CH; c++)
        begin
            if (i_calibrated_output_operation[c])
                cal_out_d[c] = i_output_on_touch ? i_touch_det[c] : i_prox_det[c]; // RULE1 RULE2
            else
                cal_out_d[c] = 1'b0;
            if (i_touch_det[c])
            begin
                touch_mode_d[c] = 1'b1; // RULE5 RULE18
                freeze_d[c]     = 1'b0; // RULE5
            end
            else if (!touch_mode_q[c])
            begin
                if (i_prox_det[c])
                    freeze_d[c] = 1'b1; // RULE4
                if (!i_prox_det[c])
                    freeze_d[c] = 1'b0;
            end
            else if (i_sample_valid && i_sample_ch == 2'(c))
            begin
                if (!i_sensing_technology_flag &&
                    {1'b0, i_sample_count} > avg_plus)
                    freeze_d[c] = 1'b1; // RULE6
                if (i_sensing_technology_flag &&
                    cnt_plus < {1'b0, i_sample_average})
                    freeze_d[c] = 1'b1; // RULE7
            end
            if (touch_mode_q[c] && !i_prox_det[c] && !i_touch_det[c])
                touch_mode_d[c] = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cal_out_q    <= 3'h0;
            freeze_q     <= 3'h0;
            touch_mode_q <= 3'h0;
        end
        else
        begin
            cal_out_q    <= cal_out_d;
            freeze_q     <= freeze_d;
            touch_mode_q <= touch_mode_d;
        end
    end

    // ------------------------------------------------------------------
    // active channel snapshot
    // ------------------------------------------------------------------
    always_comb
    begin
        ch_index_d = ch_index_q;
        count_d    = count_q;
        average_d  = average_q;
        if (i_sample_valid && i_sample_ch < 2'd3)
        begin
            ch_index_d = i_sample_ch;      // RULE8 RULE20
            count_d    = i_sample_count;   // RULE20
            average_d  = i_sample_average; // RULE20
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ch_index_q <= 2'h0;
            count_q    <= 16'h0000;
            average_q  <= 16'h0000;
        end
        else
        begin
            ch_index_q <= ch_index_d;
            count_q    <= count_d;
            average_q  <= average_d;
        end
    end

    // ------------------------------------------------------------------
    // automatic tuning: coarse compensation multiplier, then sensitivity
    // multiplier, then fine compensation, per channel
    // ------------------------------------------------------------------
    always_comb
    begin
        tune_d  = tune_q;
        tuned_d = tuned_q;
        msens_d = msens_q;
        mcomp_d = mcomp_q;
        comp_d  = comp_q;
        case (tune_q)
            CSS_TUNE_IDLE:
            begin
                if (i_retune_req)
                begin
                    tune_d  = CSS_TUNE_WAIT;
                    tuned_d = 3'h0;
                    mcomp_d = {3{css_pkg::MCOMP_RESET}};
                    msens_d = {3{css_pkg::MSENS_RESET}};
                    comp_d  = {3{css_pkg::COMP_RESET}};
                end
            end
            CSS_TUNE_WAIT:
            begin
                if (tuned_q == 3'h7)
                    tune_d = CSS_TUNE_IDLE; // RULE14
                else if (i_sample_valid && i_sample_ch < 2'd3)
                    tune_d = CSS_TUNE_STEP;
            end
            CSS_TUNE_STEP:
            begin
                tune_d = CSS_TUNE_WAIT;
                for (int c = 0; c < css_pkg::NUM_CH; c++)
                begin
                    if (ch_index_q == 2'(c) && !tuned_q[c])
                    begin
                        if (diff_up <= css_pkg::TARGET_TOL && diff_dn <= css_pkg::TARGET_TOL)
                            tuned_d[c] = 1'b1; // RULE14
                        else if (diff_up > css_pkg::TARGET_TOL &&
                                 mcomp_q[c*2 +: 2] != 2'h3 && diff_up > 16'h0100)
                            mcomp_d[c*2 +: 2] = mcomp_q[c*2 +: 2] + 2'h1; // RULE16
                        else if (diff_up > css_pkg::TARGET_TOL &&
                                 msens_q[c*4 +: 4] != 4'hf && diff_up > 16'h0020)
                            msens_d[c*4 +: 4] = msens_q[c*4 +: 4] + 4'h1; // RULE15
                        else if (diff_up > css_pkg::TARGET_TOL && comp_q[c*8 +: 8] != 8'hff)
                            comp_d[c*8 +: 8] = comp_q[c*8 +: 8] + 8'h01;
                        else if (diff_dn > css_pkg::TARGET_TOL && comp_q[c*8 +: 8] != 8'h00)
                            comp_d[c*8 +: 8] = comp_q[c*8 +: 8] - 8'h01;
                        else
                            tuned_d[c] = 1'b1;
                    end
                end
            end
            default:
                tune_d = CSS_TUNE_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            tune_q  <= CSS_TUNE_IDLE;
            tuned_q <= 3'h0;
            msens_q <= {3{css_pkg::MSENS_RESET}};
            mcomp_q <= {3{css_pkg::MCOMP_RESET}};
            comp_q  <= {3{css_pkg::COMP_RESET}};
        end
        else
        begin
            tune_q  <= tune_d;
            tuned_q <= tuned_d;
            msens_q <= msens_d;
            mcomp_q <= mcomp_d;
            comp_q  <= comp_d;
        end
    end

    // ------------------------------------------------------------------
    // register bytes
    // ------------------------------------------------------------------
    always_comb
    begin
        target_d = target_q;
        rdata_d  = rdata_q;
        rvalid_d = i_rd_en;
        if (i_wr_en && i_addr == css_pkg::ADDR_TARGET)
            target_d = i_wdata; // RULE11 RULE13
        if (i_rd_en)
        begin
            if (i_addr == css_pkg::ADDR_CAL_OUT)
                rdata_d = {5'h00, cal_out_q}; // RULE1
            else if (i_addr == css_pkg::ADDR_FREEZE)
                rdata_d = {5'h00, freeze_q}; // RULE3
            else if (i_addr == css_pkg::ADDR_CH_INDEX)
                rdata_d = {6'h00, ch_index_q}; // RULE8
            else if (i_addr == css_pkg::ADDR_COUNT_HI)
                rdata_d = count_q[15:8]; // RULE9
            else if (i_addr == css_pkg::ADDR_COUNT_LO)
                rdata_d = count_q[7:0]; // RULE9
            else if (i_addr == css_pkg::ADDR_AVG_HI)
                rdata_d = average_q[15:8]; // RULE10
            else if (i_addr == css_pkg::ADDR_AVG_LO)
                rdata_d = average_q[7:0]; // RULE10
            else if (i_addr == css_pkg::ADDR_TARGET)
                rdata_d = target_q;
            else if (i_addr == css_pkg::ADDR_SYS_FLAGS)
            begin
                rdata_d = 8'h00;
                rdata_d[css_pkg::SYS_BUSY_BIT] = (tune_q != CSS_TUNE_IDLE); // RULE17
                rdata_d[css_pkg::SYS_TECH_BIT] = i_sensing_technology_flag; // RULE19
            end
            else
                rdata_d = 8'h00;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            target_q <= css_pkg::TARGET_RESET; // RULE12
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            target_q <= target_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign o_rdata            = rdata_q;
    assign o_rvalid           = rvalid_q;
    assign o_mult_sense       = msens_q;
    assign o_mult_comp        = mcomp_q;
    assign o_comp             = comp_q;
    assign o_tuning_busy_flag = (tune_q != CSS_TUNE_IDLE); // RULE17
    assign o_tuning_target    = target_count;
endmodule : css_readout
`default_nettype wire

// File: bench/css_readout_asserts.sv
/* Port checker for css_readout: host answers, target byte, busy flag, snapshots.
   Assumes one clock and a synchronous active-high reset. */
`default_nettype none
module css_readout_asserts (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_retune_req,
    input wire logic        i_sample_valid,
    input wire logic [1:0]  i_sample_ch,
    input wire logic [15:0] i_sample_count,
    input wire logic [15:0] i_sample_average,
    input wire logic        o_tuning_busy_flag,
    input wire logic [15:0] o_tuning_target
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);
    // ----
    // checks
    // ----
    sequence snap_rd_s(logic [7:0] a);
        i_sample_valid ##1 !i_sample_valid ##1 (i_rd_en && i_addr == a && !i_sample_valid);
    endsequence
    read_answer_a: assert property (1'b1 |=> o_rvalid == $past(i_rd_en))
        else $error("read answer late or missing");
    target_write_a: assert property (i_wr_en && i_addr == 8'hc4
        |=> o_tuning_target == {5'h00, $past(i_wdata), 3'h0})
        else $error("target not eight times written byte");
    target_reset_a: assert property (disable iff (1'b0) i_rst |=> o_tuning_target == 16'h0400)
        else $error("target not 1024 after reset");
    busy_start_a: assert property (i_retune_req && !o_tuning_busy_flag |=> o_tuning_busy_flag)
        else $error("retune did not raise busy");
    busy_read_a: assert property (i_rd_en && i_addr == 8'h10
        |=> o_rdata[2] == $past(o_tuning_busy_flag))
        else $error("busy bit read wrong");
    chan_index_a: assert property (snap_rd_s(8'h3d) |=> o_rdata == {6'h00, $past(i_sample_ch, 3)})
        else $error("channel index not from last sample");
    count_high_a: assert property (snap_rd_s(8'h42)
        |=> {8'h00, o_rdata} == ($past(i_sample_count, 3) >> 8))
        else $error("count high byte wrong");
    average_low_a: assert property (snap_rd_s(8'h84)
        |=> {8'h00, o_rdata} == ($past(i_sample_average, 3) & 16'h00ff))
        else $error("average low byte wrong");
endmodule : css_readout_asserts
bind css_readout css_readout_asserts i_chk (
    .i_core_clk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
    .i_retune_req, .i_sample_valid, .i_sample_ch, .i_sample_count, .i_sample_average,
    .o_tuning_busy_flag, .o_tuning_target);
`default_nettype wire

// File: bench/css_host_model.sv
/* Host controller model: byte reads, writes and retune requests.
   Assumes a free-running clock; requests launch 1 ns after an edge. */
`default_nettype none
module css_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_retune_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {o_wr_en, o_rd_en, o_retune_req} = 3'h0;
        {o_addr, o_wdata} = 16'h0000;
    end
    // ----
    // requests
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk) #1;
        o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(posedge i_core_clk) #1;
        o_wr_en = 1'b0;
        o_addr = ~a;    // released lines show no stale value
        o_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk) #1;
        o_rd_en = 1'b1;
        o_addr = a;
        @(posedge i_core_clk) #1;
        d = i_rvalid ? i_rdata : 8'hxx;
        o_rd_en = 1'b0;
        o_addr = ~a;
    endtask : rd
    task automatic retune(input logic [7:0] t);
        wr(8'hc4, t);
        @(posedge i_core_clk) #1;
        o_retune_req = 1'b1;
        @(posedge i_core_clk) #1;
        o_retune_req = 1'b0;
    endtask : retune
endmodule : css_host_model
`default_nettype wire

// File: bench/test_css_readout.sv
/* Self-checking bench for css_readout with a host model and a front-end stub.
   Assumes the checker is bound to css_readout at elaboration. */
`default_nettype none
module test_css_readout;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] cal; logic ot; logic [2:0] p, t, e;} css_row_t;
    logic        core_clk = 1'b0, rst = 1'b1, wr_en, rd_en, rvalid, on_touch, tech;
    logic        retune, s_valid, busy;
    logic [7:0]  addr, wdata, rdata;
    logic [2:0]  cal_op, prox, touch;
    logic [1:0]  s_ch;
    logic [15:0] s_count, s_avg, target;
    logic [11:0] msens;
    logic [5:0]  mcomp;
    logic [23:0] comp;
    int          n_fail = 0, checked = 0;
    css_row_t    rows [5] = '{'{3'h7, 1'b0, 3'h5, 3'h0, 3'h5}, '{3'h7, 1'b1, 3'h5, 3'h2, 3'h2},
        '{3'h3, 1'b0, 3'h7, 3'h0, 3'h3}, '{3'h4, 1'b1, 3'h0, 3'h4, 3'h4},
        '{3'h0, 1'b0, 3'h7, 3'h7, 3'h0}};
    logic [7:0]  ra [5] = '{8'h3d, 8'h42, 8'h43, 8'h83, 8'h84};
    logic [7:0]  re [5] = '{8'h02, 8'h12, 8'h34, 8'hab, 8'hcd};
    always #5 core_clk = ~core_clk;
    css_host_model i_host (.i_core_clk(core_clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .o_retune_req(retune));
    css_readout i_dut (.i_core_clk(core_clk), .i_rst(rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_calibrated_output_operation(cal_op), .i_output_on_touch(on_touch),
        .i_sensing_technology_flag(tech), .i_retune_req(retune), .i_prox_det(prox),
        .i_touch_det(touch), .i_sample_valid(s_valid), .i_sample_ch(s_ch),
        .i_sample_count(s_count), .i_sample_average(s_avg), .o_mult_sense(msens),
        .o_mult_comp(mcomp), .o_comp(comp), .o_tuning_busy_flag(busy), .o_tuning_target(target));
    // ----
    // helpers
    // ----
    task automatic close_out;
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        check({a, d}, {a, exp});
    endtask : rd_chk
    task automatic sample(input logic [1:0] ch, input logic [15:0] c, input logic [15:0] a);
        @(posedge core_clk) #1;
        s_valid = 1'b1;
        s_ch = ch;
        s_count = c;
        s_avg = a;
        @(posedge core_clk) #1;
        s_valid = 1'b0;
        s_count = ~c;
        s_avg = ~a;
    endtask : sample
    task automatic det(input logic [2:0] p, input logic [2:0] t);
        @(posedge core_clk) #1;
        prox = p;
        touch = t;
    endtask : det
    // front end: every setting raises the count, coarse multiplier most
    function automatic logic [15:0] model_count(input int ch);
        return 16'd100 + 16'd300 * mcomp[2*ch+:2] + 16'd30 * msens[4*ch+:4] + comp[8*ch+:8];
    endfunction : model_count
    initial
    begin
        #100us;
        n_fail++;
        close_out();
    end
    initial
    begin
        logic [15:0] diff;
        {on_touch, tech, s_valid, s_ch, s_count, s_avg, cal_op, prox, touch} = '0;
        repeat (6) @(posedge core_clk);
        #1 rst = 1'b0;
        check(target, 16'h0400);
        rd_chk(8'hc4, 8'h80);
        rd_chk(8'h50, 8'h00);
        i_host.wr(8'h37, 8'hff);
        i_host.wr(8'h43, 8'h12);
        rd_chk(8'h37, 8'h00);
        check(target, 16'h0400);
        foreach (rows[i])
        begin
            @(posedge core_clk) #1;
            {cal_op, on_touch, prox, touch} = {rows[i].cal, rows[i].ot, rows[i].p, rows[i].t};
            rd_chk(8'h37, {5'h00, rows[i].e});
        end
        {cal_op, on_touch} = 4'h0;
        det(3'h0, 3'h0);
        det(3'h1, 3'h0);
        rd_chk(8'h39, 8'h01);
        det(3'h1, 3'h1);
        rd_chk(8'h39, 8'h00);
        det(3'h1, 3'h0);
        rd_chk(8'h39, 8'h00);
        sample(2'd0, 16'h0210, 16'h0200);
        rd_chk(8'h39, 8'h00);
        sample(2'd0, 16'h0211, 16'h0200);
        rd_chk(8'h39, 8'h01);
        det(3'h1, 3'h1);
        det(3'h1, 3'h0);
        tech = 1'b1;
        sample(2'd0, 16'h01f0, 16'h0200);
        rd_chk(8'h39, 8'h00);
        sample(2'd0, 16'h01ef, 16'h0200);
        rd_chk(8'h39, 8'h01);
        rd_chk(8'h10, 8'h10);
        tech = 1'b0;
        det(3'h0, 3'h0);
        foreach (ra[i])
        begin
            sample(2'd2, 16'h1234, 16'habcd);
            rd_chk(ra[i], re[i]);
        end
        i_host.retune(8'h40);
        rd_chk(8'h10, 8'h04);
        check(target, 16'h0200);
        for (int k = 0; k < 900 && busy === 1'b1; k++)
            sample(2'(k % 3), model_count(k % 3), 16'h0000);
        check({15'h0, busy}, 16'h0000);
        for (int c = 0; c < 3; c++)
        begin
            diff = model_count(c) - 16'h0200;
            check({15'h0, diff + 16'h4 > 16'h8}, 16'h0000);
        end
        close_out();
    end
endmodule : test_css_readout
`default_nettype wire
